// ===== hw/pdt_pkg.sv
package pdt_pkg;
  // ***************************************************
  // Register map (byte offsets on the Wishbone bus)
  // ***************************************************
  localparam logic [3:0] PDT_PRESCALER_OFS = 4'h0;
  localparam logic [3:0] PDT_FIRST_OFS     = 4'h4;
  localparam logic [3:0] PDT_SECOND_OFS    = 4'h8;
  localparam logic [3:0] PDT_MODE_OFS      = 4'hC;
  // ***************************************************
  // Mode register fields
  // ***************************************************
  localparam int PDT_SRC2_LSB   = 0;
  localparam int PDT_WRCTL_BIT  = 2;
  localparam int PDT_STOP_BIT   = 3;
  localparam int PDT_OUTEN_BIT  = 4;
  localparam int PDT_POL_BIT    = 5;
  localparam int PDT_PSRC_BIT   = 6;
  localparam int PDT_STAB_BIT   = 7;
  localparam int PDT_IRQ1_BIT   = 8;
  localparam int PDT_IRQ2_BIT   = 9;
  // ***************************************************
  // Reset values and dividers
  // ***************************************************
  localparam logic [7:0] PDT_PRE_RST    = 8'hFF;
  localparam logic [7:0] PDT_FIRST_RST  = 8'h01;
  localparam logic [7:0] PDT_SECOND_RST = 8'hFF;
  localparam logic [7:0] PDT_MODE_RST   = 8'h00;
  localparam int PDT_DIV16  = 16;
  localparam int PDT_DIV256 = 256;
  typedef enum logic [1:0] {
    PDT_SRC_DIV16, PDT_SRC_DIV256, PDT_SRC_PRESC, PDT_SRC_WIDE
  } pdt_src_type;
endpackage : pdt_pkg

// ===== hw/pdt_timer.sv
`timescale 1ns/10ps
// Operation
// - Each counter divides its input by one plus its reload latch value.
// - Counters decrement per count pulse; pulse at zero gives underflow.
// - Underflow reloads the counter from its latch and counting continues.
// - Each timer underflow sets that timer's interrupt request flag.
// - Prescaler is 8-bit; source is clock/16 or sub-clock by a control bit.
// - Writing the prescaler loads both its latch and its counter.
// - Reading the prescaler returns its count; reset value all ones.
// - The prescaler always counts; no stop control exists.
// - First timer is 8-bit, clocked by prescaler underflow.
// - Writing the first timer loads latch and counter together.
// - Reading the first timer returns its count; reset value one.
// - First timer has no stop and counts whenever pulses arrive.
// - Second timer source: clock/16, clock/256, prescaler, wide timer.
// - Write control bit picks latch plus counter, or latch only.
// - Second timer resets to all ones; reads return the live count.
// - Stop bit one halts the second timer; zero lets it count.
// - With output valid set, toggle pin inverts at each second underflow.
// - Polarity zero starts toggle output high, one starts it low.
// - Second timer stays accessible when stopped on another clock.
// - Stop mode with stabilise bit zero presets first timer and prescaler.
module pdt_timer
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Count sources and power mode
  input  wire logic        sub_clock_input,
  input  wire logic        wide_timer_pulse,
  input  wire logic        stop_mode_entry,
  // Outputs
  output logic             toggle_output_pin,
  output logic             firstIrq,
  output logic             secondIrq
);
  // ***************************************************
  // Registers
  // ***************************************************
  logic [7:0] preLatch_reg, preCount_reg;
  logic [7:0] firstLatch_reg, firstCount_reg;
  logic [7:0] secondLatch_reg, secondCount_reg;
  logic [7:0] mode_reg;
  logic [7:0] div_reg;
  logic [2:0] subSync_reg;
  logic       irq1_reg, irq2_reg;
  logic       wrReq, wrPre, wrFirst, wrSecond, wrMode, wrStb, rdStb;
  logic       preTick, preUnder, firstUnder, secondTick, secondUnder;
  logic       div16Tick, div256Tick, subTick;
  logic       stopPreset;
  logic [31:0] rdData_next;

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // ***************************************************
  // Bus decode
  // ***************************************************
  assign wrReq    = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  assign wrStb    = wrReq && wb_sel_i[0];
  assign rdStb    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wrPre    = wrStb && hit(wb_adr_i, PDT_PRESCALER_OFS);
  assign wrFirst  = wrStb && hit(wb_adr_i, PDT_FIRST_OFS);
  assign wrSecond = wrStb && hit(wb_adr_i, PDT_SECOND_OFS);
  assign wrMode   = wrStb && hit(wb_adr_i, PDT_MODE_OFS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rdData_next = 32'h0000_0000;
    if (hit(wb_adr_i, PDT_PRESCALER_OFS)) begin
      rdData_next = {24'h000000, preCount_reg};
    end else if (hit(wb_adr_i, PDT_FIRST_OFS)) begin
      rdData_next = {24'h000000, firstCount_reg};
    end else if (hit(wb_adr_i, PDT_SECOND_OFS)) begin
      rdData_next = {24'h000000, secondCount_reg};
    end else if (hit(wb_adr_i, PDT_MODE_OFS)) begin
      rdData_next = {22'h000000, irq2_reg, irq1_reg, mode_reg};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rdStb) begin
      wb_dat_o <= rdData_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= PDT_MODE_RST;
    end else if (wrMode) begin
      mode_reg <= wb_dat_i[7:0];
    end
  end

  // ***************************************************
  // Count sources
  // ***************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign div16Tick  = (div_reg[3:0] == 4'(PDT_DIV16 - 1));
  assign div256Tick = (div_reg == 8'(PDT_DIV256 - 1));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      subSync_reg <= 3'b000;
    end else begin
      subSync_reg <= {subSync_reg[1:0], sub_clock_input};
    end
  end
  assign subTick = subSync_reg[1] && !subSync_reg[2];

  assign preTick = mode_reg[PDT_PSRC_BIT] ? subTick : div16Tick;
  assign stopPreset = stop_mode_entry && !mode_reg[PDT_STAB_BIT];

  // ***************************************************
  // Prescaler
  // ***************************************************
  assign preUnder = preTick && (preCount_reg == 8'h00);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      preLatch_reg <= PDT_PRE_RST;
      preCount_reg <= PDT_PRE_RST;
    end else if (wrPre) begin
      preLatch_reg <= wb_dat_i[7:0];
      preCount_reg <= wb_dat_i[7:0];
    end else if (stopPreset) begin
      preCount_reg <= PDT_PRE_RST;
    end else if (preUnder) begin
      preCount_reg <= preLatch_reg;
    end else if (preTick) begin
      preCount_reg <= preCount_reg - 8'h01;
    end
  end

  // ***************************************************
  // First timer
  // ***************************************************
  assign firstUnder = preUnder && (firstCount_reg == 8'h00);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      firstLatch_reg <= PDT_FIRST_RST;
      firstCount_reg <= PDT_FIRST_RST;
    end else if (wrFirst) begin
      firstLatch_reg <= wb_dat_i[7:0];
      firstCount_reg <= wb_dat_i[7:0];
    end else if (stopPreset) begin
      firstCount_reg <= PDT_FIRST_RST;
    end else if (firstUnder) begin
      firstCount_reg <= firstLatch_reg;
    end else if (preUnder) begin
      firstCount_reg <= firstCount_reg - 8'h01;
    end
  end

  // ***************************************************
  // Second timer
  // ***************************************************
  always_comb begin
    case (pdt_src_type'(mode_reg[PDT_SRC2_LSB +: 2]))
      PDT_SRC_DIV16:  secondTick = div16Tick;
      PDT_SRC_DIV256: secondTick = div256Tick;
      PDT_SRC_PRESC:  secondTick = preUnder;
      default:        secondTick = wide_timer_pulse;
    endcase
    if (mode_reg[PDT_STOP_BIT]) begin
      secondTick = 1'b0;
    end
  end
  assign secondUnder = secondTick && (secondCount_reg == 8'h00);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      secondLatch_reg <= PDT_SECOND_RST;
    end else if (wrSecond) begin
      secondLatch_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      secondCount_reg <= PDT_SECOND_RST;
    end else if (wrSecond && !mode_reg[PDT_WRCTL_BIT]) begin
      secondCount_reg <= wb_dat_i[7:0];
    end else if (secondUnder) begin
      secondCount_reg <= secondLatch_reg;
    end else if (secondTick) begin
      secondCount_reg <= secondCount_reg - 8'h01;
    end
  end

  // ***************************************************
  // Toggle output
  // ***************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_output_pin <= 1'b1;
    end else if (!mode_reg[PDT_OUTEN_BIT]) begin
      toggle_output_pin <= !mode_reg[PDT_POL_BIT];
    end else if (secondUnder) begin
      toggle_output_pin <= !toggle_output_pin;
    end
  end

  // ***************************************************
  // Interrupt request flags
  // ***************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq1_reg <= 1'b0;
      irq2_reg <= 1'b0;
    end else begin
      if (firstUnder) begin
        irq1_reg <= 1'b1;
      end else if (wrReq && hit(wb_adr_i, PDT_MODE_OFS) && wb_sel_i[1]
                   && !wb_dat_i[PDT_IRQ1_BIT]) begin
        irq1_reg <= 1'b0;
      end
      if (secondUnder) begin
        irq2_reg <= 1'b1;
      end else if (wrReq && hit(wb_adr_i, PDT_MODE_OFS) && wb_sel_i[1]
                   && !wb_dat_i[PDT_IRQ2_BIT]) begin
        irq2_reg <= 1'b0;
      end
    end
  end
  assign firstIrq  = irq1_reg;
  assign secondIrq = irq2_reg;

  // ***************************************************
  // Checks
  // ***************************************************
  property p_preReload;
    @(posedge mclk) disable iff (!reset_n)
    (preUnder && !wrPre && !stopPreset) |=> (preCount_reg == $past(preLatch_reg));
  endproperty
  a_preReload: assert property (p_preReload) else $error("prescaler reload wrong");

  property p_preDec;
    @(posedge mclk) disable iff (!reset_n)
    (preTick && preCount_reg != 8'h00 && !wrPre && !stopPreset)
      |=> (preCount_reg == $past(preCount_reg) - 8'h01);
  endproperty
  a_preDec: assert property (p_preDec) else $error("prescaler decrement wrong");

  property p_preWrite;
    @(posedge mclk) disable iff (!reset_n)
    wrPre |=> (preCount_reg == $past(wb_dat_i[7:0]) && preLatch_reg == preCount_reg);
  endproperty
  a_preWrite: assert property (p_preWrite) else $error("prescaler write wrong");

  property p_firstWrite;
    @(posedge mclk) disable iff (!reset_n)
    wrFirst |=> (firstCount_reg == $past(wb_dat_i[7:0]) && firstLatch_reg == firstCount_reg);
  endproperty
  a_firstWrite: assert property (p_firstWrite) else $error("first timer write wrong");

  property p_irq1;
    @(posedge mclk) disable iff (!reset_n)
    firstUnder |=> irq1_reg;
  endproperty
  a_irq1: assert property (p_irq1) else $error("first irq not set");

  property p_stopHalt;
    @(posedge mclk) disable iff (!reset_n)
    (mode_reg[PDT_STOP_BIT] && !wrSecond) |=> $stable(secondCount_reg);
  endproperty
  a_stopHalt: assert property (p_stopHalt) else $error("second timer ran while stopped");

  property p_latchOnly;
    @(posedge mclk) disable iff (!reset_n)
    (wrSecond && mode_reg[PDT_WRCTL_BIT] && !secondTick) |=> $stable(secondCount_reg);
  endproperty
  a_latchOnly: assert property (p_latchOnly) else $error("latch-only write hit counter");

  property p_toggle;
    @(posedge mclk) disable iff (!reset_n)
    (secondUnder && mode_reg[PDT_OUTEN_BIT]) |=> (toggle_output_pin != $past(toggle_output_pin));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle output missed");

  property p_stopPreset;
    @(posedge mclk) disable iff (!reset_n)
    (stopPreset && !wrFirst && !wrPre)
      |=> (firstCount_reg == PDT_FIRST_RST && preCount_reg == PDT_PRE_RST);
  endproperty
  a_stopPreset: assert property (p_stopPreset) else $error("stop preset missing");

  property p_firstReload;
    @(posedge mclk) disable iff (!reset_n)
    (firstUnder && !wrFirst && !stopPreset) |=> (firstCount_reg == $past(firstLatch_reg));
  endproperty
  a_firstReload: assert property (p_firstReload) else $error("first reload wrong");

  property p_firstDec;
    @(posedge mclk) disable iff (!reset_n)
    (preUnder && firstCount_reg != 8'h00 && !wrFirst && !stopPreset)
      |=> (firstCount_reg == $past(firstCount_reg) - 8'h01);
  endproperty
  a_firstDec: assert property (p_firstDec) else $error("first decrement wrong");

  property p_firstHold;
    @(posedge mclk) disable iff (!reset_n)
    (!preUnder && !wrFirst && !stopPreset) |=> $stable(firstCount_reg);
  endproperty
  a_firstHold: assert property (p_firstHold) else $error("first moved without tick");

  property p_preHold;
    @(posedge mclk) disable iff (!reset_n)
    (!preTick && !wrPre && !stopPreset) |=> $stable(preCount_reg);
  endproperty
  a_preHold: assert property (p_preHold) else $error("prescaler moved without tick");

  property p_secondReload;
    @(posedge mclk) disable iff (!reset_n)
    (secondUnder && !wrSecond) |=> (secondCount_reg == $past(secondLatch_reg));
  endproperty
  a_secondReload: assert property (p_secondReload) else $error("second reload wrong");

  property p_secondDec;
    @(posedge mclk) disable iff (!reset_n)
    (secondTick && secondCount_reg != 8'h00 && !wrSecond)
      |=> (secondCount_reg == $past(secondCount_reg) - 8'h01);
  endproperty
  a_secondDec: assert property (p_secondDec) else $error("second decrement wrong");

  property p_secondWrite;
    @(posedge mclk) disable iff (!reset_n)
    (wrSecond && !mode_reg[PDT_WRCTL_BIT])
      |=> (secondCount_reg == $past(wb_dat_i[7:0]) && secondLatch_reg == secondCount_reg);
  endproperty
  a_secondWrite: assert property (p_secondWrite) else $error("second write wrong");

  property p_irq2;
    @(posedge mclk) disable iff (!reset_n)
    secondUnder |=> irq2_reg;
  endproperty
  a_irq2: assert property (p_irq2) else $error("second irq not set");

  property p_polarity;
    @(posedge mclk) disable iff (!reset_n)
    (!mode_reg[PDT_OUTEN_BIT]) |=> (toggle_output_pin == !$past(mode_reg[PDT_POL_BIT]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("toggle start level wrong");

  property p_toggleHold;
    @(posedge mclk) disable iff (!reset_n)
    (mode_reg[PDT_OUTEN_BIT] && !secondUnder) |=> $stable(toggle_output_pin);
  endproperty
  a_toggleHold: assert property (p_toggleHold) else $error("toggle moved without underflow");

  property p_subTick;
    @(posedge mclk) disable iff (!reset_n)
    subTick |=> !subTick;
  endproperty
  a_subTick: assert property (p_subTick) else $error("sub-clock tick too long");

  property p_div16Gap;
    @(posedge mclk) disable iff (!reset_n)
    div16Tick |=> !div16Tick;
  endproperty
  a_div16Gap: assert property (p_div16Gap) else $error("divided tick too long");
endmodule : pdt_timer

// ===== test/tb.sv
`timescale 1ns/10ps
module tb
  import pdt_pkg::*;
;
  // ********************
  // Signals and model
  // ********************
  logic        mclk      = 1'b0;
  logic        reset_n   = 1'b0;
  logic        wbCyc     = 1'b0;
  logic        wbStb     = 1'b0;
  logic        wbWe      = 1'b0;
  logic [3:0]  wbAdr     = 4'h0;
  logic [3:0]  wbSel     = 4'h0;
  logic [31:0] wbDatI    = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        subClock  = 1'b0;
  logic        widePulse = 1'b0;
  logic        stopEntry = 1'b0;
  logic        togglePin;
  logic        firstIrq;
  logic        secondIrq;
  logic [31:0] rd;
  logic [7:0]  mode;
  int          nMismatch = 0;
  int          checkCount = 0;
  int          seed = 32'h0646;
  int          pre, preL, t1, t1L, t2, t2L, irq1, irq2, tog, d1, d2;
  always #10 mclk = ~mclk;
  pdt_timer dut (
    .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .sub_clock_input(subClock), .wide_timer_pulse(widePulse),
    .stop_mode_entry(stopEntry), .toggle_output_pin(togglePin), .firstIrq(firstIrq),
    .secondIrq(secondIrq)
  );
  // ********************
  // Tasks
  // ********************
  task conclude;
    $display("Comparisons %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task chk_bit(input string name, input logic exp, input logic got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int n;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) chk_bit("wb_ack", 1'b1, wbAck);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb
  task rdchk(input string name, input logic [3:0] adr, input int exp);
    wb(1'b0, adr, 4'hF, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk
  task setmode(input logic [7:0] m);
    mode = m;
    wb(1'b1, PDT_MODE_OFS, 4'h1, {24'h0, m});
    if (!mode[PDT_OUTEN_BIT]) tog = !mode[PDT_POL_BIT];
  endtask : setmode
  task wrall(input int p, input int f, input int s);
    wb(1'b1, PDT_PRESCALER_OFS, 4'h1, p); pre = p; preL = p;
    wb(1'b1, PDT_FIRST_OFS, 4'h1, f); t1 = f; t1L = f;
    wb(1'b1, PDT_SECOND_OFS, 4'h1, s); t2L = s;
    if (!mode[PDT_WRCTL_BIT]) t2 = s;
  endtask : wrall
  task cmpall;
    rdchk("prescaler", PDT_PRESCALER_OFS, pre);
    rdchk("first", PDT_FIRST_OFS, t1);
    rdchk("second", PDT_SECOND_OFS, t2);
    rdchk("mode", PDT_MODE_OFS, {irq2[0], irq1[0], mode});
    chk_bit("toggle", tog[0], togglePin);
    chk_bit("firstIrq", irq1[0], firstIrq);
    chk_bit("secondIrq", irq2[0], secondIrq);
  endtask : cmpall
  task tick2;
    if (mode[PDT_STOP_BIT]) return;
    if (t2 == 0) begin
      t2 = t2L; irq2 = 1;
      if (mode[PDT_OUTEN_BIT]) tog = !tog;
    end else t2--;
  endtask : tick2
  task pulse(input logic wide);
    if (wide) begin
      widePulse <= 1'b1;
    end else begin
      subClock <= 1'b1;
    end
    @(posedge mclk);
    widePulse <= 1'b0;
    repeat (3) @(posedge mclk);
    subClock <= 1'b0;
    repeat (4) @(posedge mclk);
    if (wide) begin
      if (mode[1:0] == 2'd3) tick2;
    end else if (pre == 0) begin
      pre = preL;
      if (t1 == 0) begin t1 = t1L; irq1 = 1; end else t1--;
      if (mode[1:0] == 2'd2) tick2;
    end else pre--;
    cmpall;
  endtask : pulse
  task stopmode;
    @(posedge mclk); stopEntry <= 1'b1;
    @(posedge mclk); stopEntry <= 1'b0;
    repeat (2) @(posedge mclk);
    if (!mode[PDT_STAB_BIT]) begin t1 = 1; pre = 255; end
    cmpall;
  endtask : stopmode
  // ********************
  // Sequence
  // ********************
  initial begin
    pre = 255; preL = 255; t1 = 1; t1L = 1; t2 = 255; t2L = 255;
    irq1 = 0; irq2 = 0; tog = 1; mode = 8'h00;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    cmpall;
    wb(1'b1, 4'h2, 4'hF, 32'hAA);
    rdchk("unmapped", 4'h2, 0);
    setmode(8'h42);
    for (int r = 0; r < 3; r++) begin
      wrall({$random(seed)} % 4, {$random(seed)} % 3, {$random(seed)} % 4);
      setmode(8'h42 | (r == 2 ? 8'h00 : 8'h10) | (r == 1 ? 8'h20 : 8'h00));
      repeat (12) pulse(1'b0);
      wb(1'b1, PDT_MODE_OFS, 4'h2, 32'h0); irq1 = 0; irq2 = 0;
      cmpall;
    end
    wb(1'b1, PDT_PRESCALER_OFS, 4'hE, 32'h55);
    cmpall;
    setmode(8'h6A);
    wrall(1, 2, 5);
    repeat (4) pulse(1'b0);
    setmode(8'h56);
    wrall(0, 2, 3);
    repeat (8) pulse(1'b0);
    setmode(8'h43);
    repeat (7) pulse(1'b1);
    setmode(8'hC3);
    stopmode;
    setmode(8'h43);
    stopmode;
    setmode(8'h00);
    wrall(255, 5, 255);
    repeat (160) @(posedge mclk);
    wb(1'b0, PDT_PRESCALER_OFS, 4'hF, 32'h0);
    d1 = 255 - rd[7:0];
    wb(1'b0, PDT_SECOND_OFS, 4'hF, 32'h0);
    d2 = 255 - rd[7:0];
    rdchk("first", PDT_FIRST_OFS, 5);
    chk_bit("secondIrq", irq2[0], secondIrq);
    chk_bit("prescaler div16 rate", 1'b1, d1 >= 9 && d1 <= 11);
    chk_bit("second div16 rate", 1'b1, d2 >= 9 && d2 <= 11);
    setmode(8'h41);
    wrall(3, 5, 255);
    repeat (768) @(posedge mclk);
    wb(1'b0, PDT_SECOND_OFS, 4'hF, 32'h0);
    d2 = 255 - rd[7:0];
    chk_bit("second div256 rate", 1'b1, d2 >= 2 && d2 <= 4);
    rdchk("prescaler", PDT_PRESCALER_OFS, 3);
    rdchk("first", PDT_FIRST_OFS, 5);
    conclude;
  end
  initial begin
    #400000;
    nMismatch++;
    $display("Error watchdog expected end seen timeout");
    conclude;
  end
endmodule : tb
